// >>> spt_timer.sv
// Purpose: supervision timer as an LPC I/O target, eight byte registers
// Assumes: clk is the LPC clock domain; LPC pins and the 32.768 kHz tick are
//   outside signals and pass two flip-flops first
// Notes: the pin delay is covered by answering at fixed frame indices
`timescale 1ns/100ps
`default_nettype none
`include "spt_cfg.svh"

module spt_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // LPC target pins
  input wire logic lframe_n,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe,
  // Time base and options
  input wire logic tick_32k,
  input wire logic port80_kick_en,
  // Events
  output logic irq,
  output logic module_reset
);
  import spt_pkg::*;

  localparam logic [15:0] BASE = `SPT_BASE_ADDR;

  spt_regs_t st;
  spt_regs_t next_st;
  logic [3:0] cur_ix;
  logic [15:0] full_addr;
  logic [7:0] wbyte;
  logic rd_hit;
  logic wr_hit;
  logic kick80;
  logic restart;
  logic step;
  logic expire;
  logic clr_first;
  logic clr_second;

  // ==========================================================
  // Decode helpers
  function automatic logic spt_hit(input logic [15:0] a);
    return a[15:3] == BASE[15:3];
  endfunction

  function automatic logic [7:0] spt_read(input spt_regs_t s, input logic [2:0] off);
    logic [7:0] d;
    d = `SPT_BYTE_ZERO;
    case (off)
      `SPT_OFF_CNT0: d = s.count[7:0];
      `SPT_OFF_CNT1: d = s.count[15:8];
      `SPT_OFF_CNT2: d = s.count[23:16];
      `SPT_OFF_RLD0: d = s.reload[7:0];
      `SPT_OFF_RLD1: d = s.reload[15:8];
      `SPT_OFF_RLD2: d = s.reload[23:16];
      `SPT_OFF_STATUS: begin
        d[`SPT_ST_FIRST] = s.first;
        d[`SPT_ST_SECOND] = s.second;
      end
      `SPT_OFF_CTRL: begin
        d[`SPT_CT_COUNT_ENABLE_BIT] = s.count_enable_bit;
        d[`SPT_CT_RESET_ON_EXPIRY_BIT] = s.reset_on_expiry_bit;
      end
      default: d = `SPT_BYTE_ZERO;
    endcase
    return d;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    cur_ix = st.idx + `SPT_IX_ONE;
    full_addr = {st.addr[11:0], st.lpc2.ad};
    wbyte = {st.lpc2.ad, st.wlo};
    rd_hit = 1'b0;
    wr_hit = 1'b0;
    kick80 = 1'b0;
    // Synchronisers: first stage feeds only the second
    next_st.lpc1 = '{frame_n: lframe_n, ad: lad_in};
    next_st.lpc2 = st.lpc1;
    next_st.tick1 = tick_32k;
    next_st.tick2 = st.tick1;
    next_st.tick3 = st.tick2;
    next_st.p80en1 = port80_kick_en;
    next_st.p80en2 = st.p80en1;

    if (!st.lpc2.frame_n) begin
      next_st.lad_oe = 1'b0;
      next_st.idx = '0;
      next_st.state = (st.lpc2.ad == `SPT_LAD_START) ? SPT_TRACK : SPT_SKIP;
    end else begin
      case (st.state)
        SPT_IDLE: next_st.state = SPT_IDLE;
        SPT_SKIP: next_st.state = SPT_SKIP;
        SPT_TRACK: begin
          next_st.idx = cur_ix;
          if (cur_ix == `SPT_IX_CYC) begin
            next_st.is_write = st.lpc2.ad[3:1] == `SPT_CYC_IO_WR;
            if (st.lpc2.ad[3:1] != `SPT_CYC_IO_WR && st.lpc2.ad[3:1] != `SPT_CYC_IO_RD) begin
              next_st.state = SPT_SKIP;
            end
          end else if (cur_ix >= `SPT_IX_ADDR0 && cur_ix <= `SPT_IX_ADDR3) begin
            next_st.addr = full_addr;
            // read data latched at address decode
            if (cur_ix == `SPT_IX_ADDR3 && !st.is_write && spt_hit(full_addr)) begin
              rd_hit = 1'b1;
              next_st.rdata = spt_read(st, full_addr[2:0]);
              next_st.lad_oe = 1'b1;
              next_st.lad_out = `SPT_SYNC_READY;
            end
          end else if (cur_ix == `SPT_IX_WLO) begin
            next_st.wlo = st.lpc2.ad;
            next_st.lad_out = st.rdata[3:0];
          end else if (cur_ix == `SPT_IX_WHI) begin
            next_st.lad_out = st.rdata[7:4];
            if (st.is_write) begin
              wr_hit = spt_hit(st.addr);
              kick80 = (st.addr == `SPT_PORT80_ADDR) && st.p80en2;
              next_st.lad_oe = wr_hit;
              next_st.lad_out = `SPT_SYNC_READY;
            end
          end else if (cur_ix == `SPT_IX_TAR) begin
            next_st.lad_out = `SPT_LAD_TAR;
          end else begin
            next_st.lad_oe = 1'b0;
            next_st.state = SPT_IDLE;
          end
        end
        default: begin
          next_st.lad_oe = 1'b0;
          next_st.state = SPT_IDLE;
        end
      endcase
    end

    restart = wr_hit && (st.addr[2:0] <= `SPT_OFF_CNT2);
    restart = restart || kick80;
    // port 80h write also clears first
    clr_first = kick80;
    clr_second = 1'b0;
    if (wr_hit) begin
      case (st.addr[2:0])
        `SPT_OFF_RLD0: next_st.reload[7:0] = wbyte;
        `SPT_OFF_RLD1: next_st.reload[15:8] = wbyte;
        `SPT_OFF_RLD2: next_st.reload[23:16] = wbyte;
        // writing 0 leaves a flag alone
        `SPT_OFF_STATUS: begin
          clr_first = clr_first || wbyte[`SPT_ST_FIRST];
          clr_second = wbyte[`SPT_ST_SECOND];
        end
        `SPT_OFF_CTRL: begin
          next_st.count_enable_bit = wbyte[`SPT_CT_COUNT_ENABLE_BIT];
          next_st.reset_on_expiry_bit = wbyte[`SPT_CT_RESET_ON_EXPIRY_BIT];
        end
        default: next_st.reload = st.reload;
      endcase
    end

    // one step per tick rising edge
    step = st.tick2 && !st.tick3 && st.count_enable_bit && !restart;
    // count of one or zero expires on this tick
    expire = step && (st.count <= `SPT_CNT_ONE);
    if (restart || expire) begin
      // reload and continue after an expiry
      next_st.count = st.reload;
    end else if (step) begin
      next_st.count = st.count - `SPT_CNT_ONE;
    end

    // first expiry; a set beats a same-cycle clear
    next_st.first = (st.first && !clr_first) || (expire && !st.first);
    // second flag only with first set
    next_st.second = (st.second && !clr_second) || (expire && st.first);
    // interrupt held while either flag stands
    next_st.irq = next_st.first || next_st.second;

    // stretched module reset on second expiry
    if (expire && st.first && !st.second && st.reset_on_expiry_bit) begin
      next_st.hold = `SPT_RST_HOLD;
    end else if (st.hold != '0) begin
      next_st.hold = st.hold - `SPT_HOLD_ONE;
    end
    next_st.mreset = next_st.hold != '0;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '{state: SPT_IDLE, lpc1: '{frame_n: 1'b1, ad: `SPT_LAD_TAR},
              lpc2: '{frame_n: 1'b1, ad: `SPT_LAD_TAR}, count: `SPT_CNT_RST,
              reload: `SPT_CNT_RST, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign lad_out = st.lad_out;
  assign lad_oe = st.lad_oe;
  assign irq = st.irq;
  assign module_reset = st.mreset;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence seq_rd_sync;
    st.lad_oe && st.lad_out == `SPT_SYNC_READY;
  endsequence
  sequence seq_rd_data;
    st.lad_oe && st.lad_out == st.rdata[3:0] ##1 st.lad_oe && st.lad_out == st.rdata[7:4];
  endsequence
  sequence seq_rd_tar;
    st.lad_oe && st.lad_out == `SPT_LAD_TAR ##1 !st.lad_oe;
  endsequence

  a_read_answer: assert property (rd_hit && lframe_n |=> seq_rd_sync ##1 seq_rd_data ##1 seq_rd_tar)
    else $error("read cycle answer wrong");
  a_write_sync: assert property (wr_hit |=> seq_rd_sync ##1 seq_rd_tar)
    else $error("write cycle sync wrong");
  a_after_reset: assert property ($past(reset) |-> !st.count_enable_bit && !st.first && !st.second && !st.lad_oe)
    else $error("not idle after reset");
  a_count_step: assert property (step && !expire |=> st.count == $past(st.count) - `SPT_CNT_ONE)
    else $error("count did not step");
  a_count_hold: assert property (!st.count_enable_bit && !restart |=> st.count == $past(st.count))
    else $error("count moved while disabled");
  a_restart_load: assert property (restart |=> st.count == $past(st.reload))
    else $error("restart did not reload");
  a_kick80_clear: assert property (kick80 && !expire |=> !st.first && st.count == $past(st.reload))
    else $error("port 80h kick ignored");
  a_first_set: assert property (expire && !st.first |=> st.first && st.irq && st.count == $past(st.reload))
    else $error("first expiry missed");
  a_second_set: assert property (expire && st.first |=> st.second && st.irq)
    else $error("second expiry missed");
  a_second_cause: assert property ($rose(st.second) |-> $past(st.first) && $past(expire))
    else $error("second flag without first");
  a_reset_out: assert property ($rose(st.second) && $past(st.reset_on_expiry_bit) |-> st.mreset ##15 st.mreset ##1 !st.mreset)
    else $error("module reset pulse wrong");
  a_w1c_first: assert property (clr_first && !expire |=> !st.first)
    else $error("first flag not cleared");
  a_ctrl_read: assert property (rd_hit && full_addr[2:0] == `SPT_OFF_CTRL |=> st.rdata[7:2] == '0)
    else $error("reserved bits not zero");

  // ==========================================================
  // Bus window, register reads and writes, and flag upkeep
  // A drive that starts outside the window would fight another target
  a_window_only: assert property ($rose(st.lad_oe) |-> spt_hit(st.addr))
    else $error("drive outside the window");
  a_abort_quiet: assert property (!st.lpc2.frame_n |=> !st.lad_oe)
    else $error("drive kept through a new frame");
  a_count_read: assert property (rd_hit && full_addr[2:0] == `SPT_OFF_CNT2
    |=> st.rdata == $past(st.count[23:16]))
    else $error("count byte read wrong");
  a_reload_write: assert property (wr_hit && st.addr[2:0] == `SPT_OFF_RLD2
    |=> st.reload[23:16] == $past(wbyte))
    else $error("reload byte write lost");
  a_ctrl_write: assert property (wr_hit && st.addr[2:0] == `SPT_OFF_CTRL
    |=> st.count_enable_bit == $past(wbyte[`SPT_CT_COUNT_ENABLE_BIT]) && st.reset_on_expiry_bit == $past(wbyte[`SPT_CT_RESET_ON_EXPIRY_BIT]))
    else $error("control write lost");
  a_idle_flags: assert property (!st.count_enable_bit |=> !$rose(st.first) && !$rose(st.second))
    else $error("flag set while stopped");
  a_irq_level: assert property (st.irq == (st.first || st.second))
    else $error("interrupt not tied to flags");
  // Writing zero or a reserved bit must never drop a flag
  a_first_keep: assert property (st.first && !clr_first |=> st.first)
    else $error("first flag lost");
  a_second_keep: assert property (st.second && !clr_second |=> st.second)
    else $error("second flag lost");
  a_status_rsvd: assert property (rd_hit && full_addr[2:0] == `SPT_OFF_STATUS
    |=> st.rdata[7:3] == '0 && !st.rdata[1])
    else $error("status reserved bits not zero");
  a_reset_quiet: assert property ($rose(st.second) && !$past(st.reset_on_expiry_bit) |-> !st.mreset)
    else $error("module reset while disabled");
endmodule
`default_nettype wire

// >>> spt_cfg.svh
// Purpose: constants of the supervision timer LPC target
// Assumes: included by bare name from the package and the module
// Notes: offsets are byte offsets from the I/O base
`ifndef SPT_CFG_SVH
`define SPT_CFG_SVH

// ==========================================================
// I/O decode
`define SPT_BASE_ADDR 16'h0A00
`define SPT_PORT80_ADDR 16'h0080
`define SPT_OFF_CNT0 3'h0
`define SPT_OFF_CNT1 3'h1
`define SPT_OFF_CNT2 3'h2
`define SPT_OFF_RLD0 3'h3
`define SPT_OFF_RLD1 3'h4
`define SPT_OFF_RLD2 3'h5
`define SPT_OFF_STATUS 3'h6
`define SPT_OFF_CTRL 3'h7

// ==========================================================
// Field positions
`define SPT_ST_FIRST 0
`define SPT_ST_SECOND 2
`define SPT_CT_RESET_ON_EXPIRY_BIT 0
`define SPT_CT_COUNT_ENABLE_BIT 1

// ==========================================================
// LPC frame coding and frame cycle indices
`define SPT_LAD_START 4'h0
`define SPT_CYC_IO_RD 3'h0
`define SPT_CYC_IO_WR 3'h1
`define SPT_SYNC_READY 4'h0
`define SPT_LAD_TAR 4'hF
`define SPT_IX_CYC 4'h1
`define SPT_IX_ADDR0 4'h2
`define SPT_IX_ADDR3 4'h5
`define SPT_IX_WLO 4'h6
`define SPT_IX_WHI 4'h7
`define SPT_IX_TAR 4'h8
`define SPT_IX_LAST 4'h9
`define SPT_IX_ONE 4'h1

// ==========================================================
// Reset values and timing
`define SPT_CNT_RST 24'h000000
`define SPT_CNT_ONE 24'h000001
`define SPT_BYTE_ZERO 8'h00
`define SPT_RST_HOLD 8'h10
`define SPT_HOLD_ONE 8'h01

`endif

// >>> spt_pkg.sv
// Purpose: types of the supervision timer LPC target
// Assumes: spt_cfg.svh holds the numeric constants
// Notes: all module state is the one struct spt_regs_t
`default_nettype none
package spt_pkg;
  `include "spt_cfg.svh"

  typedef enum logic [2:0] {
    SPT_IDLE = 3'b001,
    SPT_TRACK = 3'b010,
    SPT_SKIP = 3'b100
  } spt_state_t;

  typedef struct packed {
    logic frame_n;
    logic [3:0] ad;
  } spt_lpc_t;

  typedef struct packed {
    spt_lpc_t lpc1;
    spt_lpc_t lpc2;
    logic tick1;
    logic tick2;
    logic tick3;
    logic p80en1;
    logic p80en2;
    spt_state_t state;
    logic [3:0] idx;
    logic is_write;
    logic [15:0] addr;
    logic [3:0] wlo;
    logic [7:0] rdata;
    logic [23:0] count;
    logic [23:0] reload;
    logic first;
    logic second;
    logic count_enable_bit;
    logic reset_on_expiry_bit;
    logic lad_oe;
    logic [3:0] lad_out;
    logic irq;
    logic mreset;
    logic [7:0] hold;
  } spt_regs_t;
endpackage
`default_nettype wire

// >>> spt_lpc_host.sv
// Purpose: LPC host model issuing I/O cycles to the timer
// Assumes: pins change 1 ns after the rising clock edge
// Notes: a released LAD line reads F through its pull-ups
`timescale 1ns/100ps
`default_nettype none
module spt_lpc_host (
  // Clock
  input wire logic clk,
  // LPC pins
  output logic lframe_n,
  output logic [3:0] lad_drv,
  input wire logic [3:0] lad,
  input wire logic lad_oe
);
  initial begin
    lframe_n = 1'b1;
    lad_drv = 4'hF;
  end

  // ==========================================================
  // One nibble per clock
  task automatic put(input logic fr, input logic [3:0] v);
    @(posedge clk);
    #1;
    lframe_n = fr;
    lad_drv = v;
  endtask

  // ==========================================================
  // Whole I/O frame; ok is high when a ready sync came back
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d,
                    output logic ok, output logic [7:0] q);
    ok = 1'b0;
    q = 8'h00;
    put(1'b0, 4'h0);
    put(1'b1, wr ? 4'h2 : 4'h0);
    for (int i = 3; i >= 0; i--) put(1'b1, a[i*4 +: 4]);
    if (wr) begin
      put(1'b1, d[3:0]);
      put(1'b1, d[7:4]);
    end
    // Turnaround, then the line is left to the pull-ups
    put(1'b1, 4'hF);
    put(1'b1, 4'hF);
    for (int i = 0; i < 8 && ok !== 1'b1; i++) begin
      @(negedge clk);
      ok = lad_oe && (lad === 4'h0);
    end
    if (ok === 1'b1 && !wr) begin
      @(negedge clk);
      q[3:0] = lad;
      @(negedge clk);
      q[7:4] = lad;
    end
    for (int i = 0; i < 8 && lad_oe !== 1'b0; i++) @(negedge clk);
    put(1'b1, 4'hF);
  endtask
endmodule
`default_nettype wire

// >>> test_spt_timer.sv
// Purpose: register-level test of the supervision timer
// Assumes: ticks come at the 32.768 kHz rate, 3815 clocks each
// Notes: ticks are issued only by the bench, so counts are exact
`timescale 1ns/100ps
`default_nettype none
`include "spt_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module test_spt_timer;
  logic clk, reset, tick_32k, port80_kick_en, ok;
  logic [7:0] q;
  wire logic lframe_n, lad_oe, irq, module_reset;
  wire logic [3:0] lad_drv, lad_out;
  // Wire level of LAD seen by both parties
  wire logic [3:0] lad = lad_oe ? lad_out : lad_drv;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int mr_len = 0;

  spt_timer dut_u (.clk(clk), .reset(reset), .lframe_n(lframe_n), .lad_in(lad),
    .lad_out(lad_out), .lad_oe(lad_oe), .tick_32k(tick_32k),
    .port80_kick_en(port80_kick_en), .irq(irq), .module_reset(module_reset));
  spt_lpc_host host_u (.clk(clk), .lframe_n(lframe_n), .lad_drv(lad_drv), .lad(lad), .lad_oe(lad_oe));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Watchdog of the bench and reset pulse length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors++;
      results();
    end
  end
  always @(negedge clk) if (module_reset === 1'b1) mr_len++;

  task automatic results;
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Register access and time base
  task automatic wr(input logic [2:0] o, input logic [7:0] d);
    host_u.io(1'b1, `SPT_BASE_ADDR + 16'(o), d, ok, q);
    `CHK(ok, 1'b1)
  endtask
  task automatic rd(input logic [2:0] o, input logic [7:0] e);
    host_u.io(1'b0, `SPT_BASE_ADDR + 16'(o), 8'h00, ok, q);
    `CHK({ok, q}, {1'b1, e})
  endtask
  task automatic cnt(input logic [23:0] v);
    for (int o = 0; o < 3; o++) rd(o[2:0], v[o*8 +: 8]);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      repeat (1907) @(posedge clk);
      #1 tick_32k = 1'b1;
      repeat (1908) @(posedge clk);
      #1 tick_32k = 1'b0;
    end
    repeat (8) @(posedge clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    tick_32k = 1'b0;
    port80_kick_en = 1'b0;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    for (int o = 0; o < 8; o++) rd(o[2:0], 8'h00);
    // Stop, load, restart, then enable
    wr(3'h7, 8'h00);
    for (int o = 3; o < 6; o++) wr(o[2:0], 8'(o - 2));
    for (int o = 3; o < 6; o++) rd(o[2:0], 8'(o - 2));
    wr(3'h1, 8'hAA);
    cnt(24'h030201);
    wr(3'h7, 8'hFE);
    rd(3'h7, 8'h02);
    ticks(2);
    cnt(24'h0301FF);
    wr(3'h7, 8'h00);
    ticks(1);
    cnt(24'h0301FF);
    // Two-tick timeout, reset on expiry left off
    for (int o = 3; o < 6; o++) wr(o[2:0], (o == 3) ? 8'h02 : 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h7, 8'h02);
    ticks(2);
    rd(3'h6, 8'h01);
    `CHK(irq, 1'b1)
    cnt(24'h000002);
    ticks(2);
    rd(3'h6, 8'h05);
    `CHK(mr_len, 0)
    wr(3'h6, 8'h00);
    rd(3'h6, 8'h05);
    wr(3'h6, 8'h04);
    rd(3'h6, 8'h01);
    wr(3'h6, 8'h01);
    rd(3'h6, 8'h00);
    `CHK(irq, 1'b0)
    // Port 80h kick clears the flag and restarts
    port80_kick_en = 1'b1;
    ticks(3);
    host_u.io(1'b1, `SPT_PORT80_ADDR, 8'h55, ok, q);
    `CHK(ok, 1'b0)
    rd(3'h6, 8'h00);
    cnt(24'h000002);
    // Kicks faster than the timeout keep the flags clear
    ticks(1);
    wr(3'h2, 8'h00);
    ticks(1);
    rd(3'h6, 8'h00);
    cnt(24'h000001);
    host_u.io(1'b0, `SPT_BASE_ADDR + 16'h0008, 8'h00, ok, q);
    `CHK(ok, 1'b0)
    wr(3'h7, 8'h03);
    ticks(4);
    rd(3'h6, 8'h05);
    `CHK(mr_len, int'(`SPT_RST_HOLD))
    // Reset in mid-run brings every register back to idle
    @(posedge clk);
    #1 reset = 1'b1;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    for (int o = 0; o < 8; o++) rd(o[2:0], 8'h00);
    `CHK(irq, 1'b0)
    results();
  end
endmodule
`default_nettype wire
